// ---- rtl/usc_core.sv ----
// Status FIFO, control and address registers of a full-speed USB link.
// Assumes transaction events and token activity come from the link engine
// on core_clk; bus line levels arrive asynchronous from the transceiver.

`timescale 1ns/1ns
`default_nettype none

module usc_core #(
   parameter int SOF_CYCLES = usc_pkg::SOF_CYCLES
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire usc_pkg::usc_done_type done_in,
   input wire logic token_active,
   input wire logic line_j_async,
   input wire logic line_se0_async,
   output logic fifo_overflow,
   output logic module_enable,
   output logic host_mode,
   output logic host_logic_reset,
   output logic bus_reset_drive,
   output logic resume_drive,
   output logic ls_eop_drive,
   output logic pingpong_pointer_clear,
   output logic packet_processing_hold,
   output logic sof_pulse,
   output logic low_speed_select,
   output logic [6:0] device_bus_address
);

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   logic wr_con;
   logic wr_addr;
   logic wr_flag;
   assign wr_con = reg_wr && hit(reg_addr, usc_pkg::ADDR_CONTROL);
   assign wr_addr = reg_wr && hit(reg_addr, usc_pkg::ADDR_ADDRESS);
   assign wr_flag = reg_wr && hit(reg_addr, usc_pkg::ADDR_FLAGS);

   // ----------------------------------------------------------------
   // Line level synchronisers
   // ----------------------------------------------------------------
   logic [1:0] j_sync_r;
   logic [1:0] se0_sync_r;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         j_sync_r <= 2'h0;
         se0_sync_r <= 2'h0;
      end else begin
         j_sync_r <= {j_sync_r[0], line_j_async};
         se0_sync_r <= {se0_sync_r[0], line_se0_async};
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   logic hold_r;
   logic bus_rst_r;
   logic host_en_r;
   logic resume_r;
   logic ppclr_r;
   logic en_r;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         bus_rst_r <= 1'b0;
         host_en_r <= 1'b0;
         resume_r <= 1'b0;
         ppclr_r <= 1'b0;
         en_r <= 1'b0;
      end else if (wr_con) begin
         bus_rst_r <= reg_wdata[usc_pkg::CON_RST_BIT];
         host_en_r <= reg_wdata[usc_pkg::CON_HOST_BIT];
         resume_r <= reg_wdata[usc_pkg::CON_RESUME_BIT];
         ppclr_r <= reg_wdata[usc_pkg::CON_PPCLR_BIT];
         en_r <= reg_wdata[usc_pkg::CON_EN_BIT];
      end
   end

   // Setup wins over a simultaneous software clear
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         hold_r <= 1'b0;
      end else if (!host_en_r && done_in.valid && done_in.setup) begin
         hold_r <= 1'b1;
      end else if (wr_con && !host_en_r) begin
         hold_r <= reg_wdata[usc_pkg::CON_HOLD_BIT];
      end
   end

   // Host logic reset pulses on either edge of the host enable bit
   logic host_en_d_r;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         host_en_d_r <= 1'b0;
      end else begin
         host_en_d_r <= host_en_r;
      end
   end
   assign host_logic_reset = host_en_r ^ host_en_d_r;

   assign host_mode = host_en_r;
   assign module_enable = en_r && !host_en_r;
   assign bus_reset_drive = bus_rst_r && host_en_r;
   assign pingpong_pointer_clear = ppclr_r;
   assign packet_processing_hold = hold_r && !host_en_r;

   // ----------------------------------------------------------------
   // Resume and trailing low-speed EOP
   // ----------------------------------------------------------------
   usc_pkg::usc_resume_type res_state_r;
   logic [8:0] eop_cnt_r;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         res_state_r <= usc_pkg::RES_IDLE;
         eop_cnt_r <= 9'h000;
      end else begin
         case (res_state_r)
            usc_pkg::RES_IDLE: begin
               if (resume_r) begin
                  res_state_r <= usc_pkg::RES_DRIVE;
               end
            end
            usc_pkg::RES_DRIVE: begin
               if (!resume_r && host_en_r) begin
                  res_state_r <= usc_pkg::RES_EOP;
                  eop_cnt_r <= 9'(usc_pkg::LS_EOP_CYCLES - 1);
               end else if (!resume_r) begin
                  res_state_r <= usc_pkg::RES_IDLE;
               end
            end
            usc_pkg::RES_EOP: begin
               // A fresh resume request cuts the trailing EOP short
               if (resume_r) begin
                  res_state_r <= usc_pkg::RES_DRIVE;
               end else if (eop_cnt_r == 9'h000) begin
                  res_state_r <= usc_pkg::RES_IDLE;
               end else begin
                  eop_cnt_r <= eop_cnt_r - 9'h001;
               end
            end
            default: begin
               res_state_r <= usc_pkg::RES_IDLE;
            end
         endcase
      end
   end
   assign resume_drive = resume_r;
   // Masked so a host disable mid-EOP releases the line at once
   assign ls_eop_drive = (res_state_r == usc_pkg::RES_EOP) && host_en_r
                         && !resume_r;

   // ----------------------------------------------------------------
   // Frame start timer, host mode only
   // ----------------------------------------------------------------
   logic [31:0] sof_cnt_r;
   logic sof_r;
   always_ff @(posedge core_clk) begin
      if (!resetn || host_logic_reset || !(host_en_r && en_r)) begin
         sof_cnt_r <= 32'h0000_0000;
         sof_r <= 1'b0;
      end else if (sof_cnt_r == 32'(SOF_CYCLES - 1)) begin
         sof_cnt_r <= 32'h0000_0000;
         sof_r <= 1'b1;
      end else begin
         sof_cnt_r <= sof_cnt_r + 32'h0000_0001;
         sof_r <= 1'b0;
      end
   end
   // Masked so a pulse never outlives the enable that launched it
   assign sof_pulse = sof_r && host_en_r && en_r;

   // ----------------------------------------------------------------
   // Address register
   // ----------------------------------------------------------------
   logic ls_r;
   logic [6:0] dev_addr_r;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ls_r <= 1'b0;
         dev_addr_r <= usc_pkg::DEV_ADDR_RESET;
      end else if (wr_addr) begin
         ls_r <= reg_wdata[usc_pkg::ADDR_LS_BIT];
         dev_addr_r <= reg_wdata[6:0];
      end
   end
   assign low_speed_select = ls_r;
   assign device_bus_address = dev_addr_r;

   // ----------------------------------------------------------------
   // Status FIFO
   // ----------------------------------------------------------------
   // Entries arriving while full are dropped and flagged unless a pop lands in the same cycle.
   usc_pkg::usc_status_type fifo_mem_r [usc_pkg::FIFO_DEPTH];
   logic [1:0] wr_ptr_r;
   logic [1:0] rd_ptr_r;
   logic [2:0] count_r;
   logic push;
   logic pop;
   logic full;
   logic trn_flag;

   assign full = (count_r == usc_pkg::FIFO_FULL_COUNT);
   assign trn_flag = (count_r != 3'h0);
   // Software clears by writing 1 to the flag bit
   assign pop = wr_flag && reg_wdata[usc_pkg::FLAG_TRN_BIT] && trn_flag;
   assign push = done_in.valid && (!full || pop);

   always_ff @(posedge core_clk) begin
      if (push) begin
         fifo_mem_r[wr_ptr_r] <= done_in.status;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn || host_logic_reset) begin
         wr_ptr_r <= 2'h0;
         rd_ptr_r <= 2'h0;
         count_r <= 3'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 2'h1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 2'h1;
         end
         count_r <= count_r + {2'h0, push} - {2'h0, pop};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         fifo_overflow <= 1'b0;
      end else begin
         fifo_overflow <= done_in.valid && full && !pop;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   usc_pkg::usc_status_type head;
   assign head = fifo_mem_r[rd_ptr_r];

   logic [31:0] rd_nxt;
   always_comb begin
      rd_nxt = usc_pkg::READ_ZERO;
      case (reg_addr)
         usc_pkg::ADDR_STATUS: begin
            if (trn_flag) begin
               rd_nxt[usc_pkg::STAT_EP_LSB +: 4] = head.endpoint;
               rd_nxt[usc_pkg::STAT_DIR_BIT] = head.tx_dir;
               rd_nxt[usc_pkg::STAT_PINGPONG_BANK_INDICATOR_BIT] = head.odd_bank;
            end
         end
         usc_pkg::ADDR_CONTROL: begin
            rd_nxt[usc_pkg::CON_J_BIT] = j_sync_r[1];
            rd_nxt[usc_pkg::CON_SE0_BIT] = se0_sync_r[1];
            // Host mode reads token busy in the hold position
            rd_nxt[usc_pkg::CON_HOLD_BIT] = host_en_r ? token_active
                                                      : hold_r;
            rd_nxt[usc_pkg::CON_RST_BIT] = bus_rst_r;
            rd_nxt[usc_pkg::CON_HOST_BIT] = host_en_r;
            rd_nxt[usc_pkg::CON_RESUME_BIT] = resume_r;
            rd_nxt[usc_pkg::CON_PPCLR_BIT] = ppclr_r;
            rd_nxt[usc_pkg::CON_EN_BIT] = en_r;
         end
         usc_pkg::ADDR_ADDRESS: begin
            rd_nxt[usc_pkg::ADDR_LS_BIT] = ls_r;
            rd_nxt[6:0] = dev_addr_r;
         end
         usc_pkg::ADDR_FLAGS: begin
            rd_nxt[usc_pkg::FLAG_TRN_BIT] = trn_flag;
         end
         default: begin
            rd_nxt = usc_pkg::READ_ZERO;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         reg_rdata <= usc_pkg::READ_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= rd_nxt;
      end else begin
         reg_rdata <= usc_pkg::READ_ZERO;
      end
   end

endmodule : usc_core

`default_nettype wire

// ---- rtl/usc_pkg.sv ----
// Package for the status, control and address register block.
// Assumes a single 250 MHz core clock and a plain strobe register port.

package usc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_ADDRESS = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int STAT_EP_LSB = 4;
   localparam int STAT_DIR_BIT = 3;
   localparam int STAT_PINGPONG_BANK_INDICATOR_BIT = 2;
   localparam int CON_J_BIT = 7;
   localparam int CON_SE0_BIT = 6;
   localparam int CON_HOLD_BIT = 5;
   localparam int CON_RST_BIT = 4;
   localparam int CON_HOST_BIT = 3;
   localparam int CON_RESUME_BIT = 2;
   localparam int CON_PPCLR_BIT = 1;
   localparam int CON_EN_BIT = 0;
   localparam int ADDR_LS_BIT = 7;
   localparam int FLAG_TRN_BIT = 0;

   // ----------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH = 4;
   localparam logic [2:0] FIFO_FULL_COUNT = 3'h4;
   localparam logic [6:0] DEV_ADDR_RESET = 7'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int SOF_PERIOD_US = 1000;
   localparam int SOF_CYCLES = SOF_PERIOD_US * CLK_MHZ;
   localparam int LS_EOP_NS = 1334;
   localparam int LS_EOP_CYCLES = (LS_EOP_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] endpoint;
      logic tx_dir;
      logic odd_bank;
   } usc_status_type;

   typedef struct packed {
      logic valid;
      logic setup;
      usc_status_type status;
   } usc_done_type;

   typedef enum logic [2:0] {
      RES_IDLE = 3'b001,
      RES_DRIVE = 3'b010,
      RES_EOP = 3'b100
   } usc_resume_type;

endpackage : usc_pkg

// ---- test/usc_core_checker.sv ----
// Checker on the ports of usc_core.
// Assumes it is bound into every instance of usc_core.
`timescale 1ns/1ns
`default_nettype none
module usc_core_checker (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire usc_pkg::usc_done_type done_in,
   input wire logic fifo_overflow,
   input wire logic module_enable,
   input wire logic host_mode,
   input wire logic host_logic_reset,
   input wire logic bus_reset_drive,
   input wire logic resume_drive,
   input wire logic ls_eop_drive,
   input wire logic sof_pulse,
   input wire logic packet_processing_hold
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_rdata_idle;
      !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read cycle");
   property p_upper_zero;
      $past(reg_rd) |-> reg_rdata[31:8] == 24'h00_0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper read bits not zero");
   property p_rst_host;
      bus_reset_drive |-> host_mode;
   endproperty
   a_rst_host: assert property (p_rst_host)
      else $error("bus reset driven outside host mode");
   property p_en_dev;
      module_enable |-> !host_mode;
   endproperty
   a_en_dev: assert property (p_en_dev)
      else $error("module enable in host mode");
   property p_host_toggle;
      $changed(host_mode) |-> ##[0:1] host_logic_reset;
   endproperty
   a_host_toggle: assert property (p_host_toggle)
      else $error("host logic not reset on host toggle");
   property p_sof;
      sof_pulse |-> host_mode ##1 !sof_pulse;
   endproperty
   a_sof: assert property (p_sof)
      else $error("frame start pulse malformed");
   property p_eop;
      ls_eop_drive |-> host_mode && !resume_drive;
   endproperty
   a_eop: assert property (p_eop)
      else $error("end of packet out of place");
   property p_setup_hold;
      done_in.valid && done_in.setup && !host_mode |=> packet_processing_hold;
   endproperty
   a_setup_hold: assert property (p_setup_hold)
      else $error("setup did not hold packet processing");
   property p_ovf;
      fifo_overflow |-> $past(done_in.valid);
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow without a push");
endmodule : usc_core_checker
bind usc_core usc_core_checker chk (.core_clk(core_clk), .resetn(resetn),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .done_in(done_in),
   .fifo_overflow(fifo_overflow), .module_enable(module_enable),
   .host_mode(host_mode), .host_logic_reset(host_logic_reset),
   .bus_reset_drive(bus_reset_drive), .resume_drive(resume_drive),
   .ls_eop_drive(ls_eop_drive), .sof_pulse(sof_pulse),
   .packet_processing_hold(packet_processing_hold));
`default_nettype wire

// ---- test/usc_core_tb.sv ----
// Register-level bench for usc_core with the far-side line model.
// Assumes SOF_CYCLES shortened to 20 so frame timing runs quickly.
`timescale 1ns/1ns
`default_nettype none
module usc_core_tb;
   logic core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic line_j, line_se0, token_active, ovf, men, hm, hlr, brd, rsd, eop;
   logic ppc, pph, sof, lss;
   logic [6:0] dba;
   usc_pkg::usc_done_type done;
   int error_cnt = 0, checks = 0, hlr_cnt = 0, ovf_cnt = 0, n;
   logic [3:0] eps [5] = '{4'hf, 4'h0, 4'h9, 4'h6, 4'h3};
   usc_line_model model (.core_clk(core_clk), .line_j(line_j),
      .line_se0(line_se0), .done(done), .busy(token_active));
   usc_core #(.SOF_CYCLES(20)) uut (.core_clk(core_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .done_in(done),
      .token_active(token_active), .line_j_async(line_j),
      .line_se0_async(line_se0), .fifo_overflow(ovf), .module_enable(men),
      .host_mode(hm), .host_logic_reset(hlr), .bus_reset_drive(brd),
      .resume_drive(rsd), .ls_eop_drive(eop), .pingpong_pointer_clear(ppc),
      .packet_processing_hold(pph), .sof_pulse(sof),
      .low_speed_select(lss), .device_bus_address(dba));
   initial forever #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (hlr === 1'b1) hlr_cnt++;
      if (ovf === 1'b1) ovf_cnt++;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
      logic [31:0] v;
      rd(a, v);
      chk(nm, v, e);
   endtask : rc
   initial begin
      #200000 error_cnt++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      // -------------------------------------------------------------
      // Reset values, unmapped space, address register
      // -------------------------------------------------------------
      rc(8'h00, 32'h0, "status");
      rc(8'h04, 32'h0, "control");
      rc(8'h08, 32'h0, "address");
      wr(8'h10, 32'hffff_ffff);
      rc(8'h10, 32'h0, "unmapped");
      wr(8'h08, 32'hffff_ffff);
      rc(8'h08, 32'h0000_00ff, "address");
      chk("low_speed", lss, 1'b1);
      chk("dev_addr", dba, 7'h7f);
      // -------------------------------------------------------------
      // Status FIFO: five pushes into four places, then drain
      // -------------------------------------------------------------
      for (int i = 0; i < 5; i++) model.send_done(eps[i], i[0], i[1], 1'b0);
      @(posedge core_clk);
      // Let the edge counter settle before looking at it
      #1 chk("overflow", ovf_cnt, 1);
      for (int i = 0; i < 4; i++) begin
         rc(8'h0c, 32'h1, "flag");
         rc(8'h00, {eps[i], i[0], i[1], 2'b00}, "status");
         wr(8'h0c, 32'h1);
      end
      rc(8'h0c, 32'h0, "flag");
      rc(8'h00, 32'h0, "status");
      // -------------------------------------------------------------
      // Live line flags and SETUP hold in device mode
      // -------------------------------------------------------------
      model.set_line(1'b1, 1'b0);
      repeat (4) @(posedge core_clk);
      rc(8'h04, 32'h80, "j_flag");
      model.set_line(1'b0, 1'b1);
      repeat (4) @(posedge core_clk);
      rc(8'h04, 32'h40, "se0_flag");
      model.set_line(1'b0, 1'b0);
      model.send_done(4'h2, 1'b0, 1'b0, 1'b1);
      rc(8'h04, 32'h20, "hold");
      chk("hold_out", pph, 1'b1);
      wr(8'h04, 32'h0);
      rc(8'h04, 32'h0, "hold");
      wr(8'h0c, 32'h1);
      wr(8'h04, 32'h17);
      #1 chk("dev_outs", {men, brd, rsd, ppc}, 4'b1011);
      wr(8'h04, 32'h0);
      // -------------------------------------------------------------
      // Host mode: busy, bus reset, frame start, resume end of packet
      // -------------------------------------------------------------
      wr(8'h04, 32'h08);
      model.set_busy(1'b1);
      rc(8'h04, 32'h28, "busy");
      model.set_busy(1'b0);
      rc(8'h04, 32'h08, "busy");
      wr(8'h04, 32'h19);
      #1 chk("host_outs", {brd, men, hm}, 3'b101);
      n = 0;
      while (sof !== 1'b1 && n < 100) begin @(posedge core_clk); #1 n++; end
      n = 0;
      do begin @(posedge core_clk); #1 n++; end while (sof !== 1'b1 && n < 100);
      chk("sof_gap", n, 20);
      wr(8'h04, 32'h0c);
      #1 chk("resume", rsd, 1'b1);
      wr(8'h04, 32'h08);
      n = 0;
      repeat (400) begin @(posedge core_clk); #1 if (eop === 1'b1) n++; end
      chk("eop_len", n, usc_pkg::LS_EOP_CYCLES);
      wr(8'h04, 32'h0);
      @(posedge core_clk);
      #1 chk("host_resets", hlr_cnt, 2);
      conclude();
   end
endmodule : usc_core_tb
`default_nettype wire

// ---- test/usc_line_model.sv ----
// Far-side model: bus line levels, completed transactions, token activity.
// Assumes the bench calls its tasks from a process synchronised to core_clk.
`timescale 1ns/1ns
`default_nettype none
module usc_line_model (
   input wire logic core_clk,
   output logic line_j,
   output logic line_se0,
   output usc_pkg::usc_done_type done,
   output logic busy
);
   initial begin
      line_j = 1'b0;
      line_se0 = 1'b0;
      done = '0;
      busy = 1'b0;
   end
   // One-cycle completion pulse, as the link engine gives it
   task automatic send_done(input logic [3:0] ep, input logic tx,
                            input logic odd, input logic setup);
      @(posedge core_clk);
      done <= {1'b1, setup, ep, tx, odd};
      @(posedge core_clk);
      done.valid <= 1'b0;
   endtask : send_done
   task automatic set_line(input logic j, input logic se0);
      @(posedge core_clk);
      line_j <= j;
      line_se0 <= se0;
   endtask : set_line
   // Token activity of the link engine, read back as token busy
   task automatic set_busy(input logic b);
      @(posedge core_clk);
      busy <= b;
   endtask : set_busy
endmodule : usc_line_model
`default_nettype wire
